//--- mas_top.sv
// Modulo ALU, fast memory write-back and double halfword store datapath
module mas_top
    import mas_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Cell buffer held by other ports
    input wire logic MEM_BUSY_I,
    // Fast memory write-back
    output logic FM_WE_O,
    output logic [15:0] FM_ADDR_O,
    output logic [15:0] FM_DATA_O,
    // Interrupt
    output logic IRQ_O
);
    import mas_pkg::*;

    if (MEM_AW < 2 || MEM_AW > 8) begin : g_chk
        $error("mas_top: MEM_AW must be 2 to 8");
    end

    logic [15:0] opa_r;
    logic [15:0] opb_r;
    logic [15:0] base_r;
    logic [15:0] fmlink_r;
    logic [15:0] res_r;
    logic ovf_r;
    logic brt_r;
    logic [4:0] seq_r;
    logic [MAS_EV_N-1:0] stat_r;
    logic [MAS_EV_N-1:0] ie_r;
    logic fm_we_r;
    logic [15:0] fm_data_r;
    mas_wb_t wb_r;
    logic [MEM_AW-1:0] wb_addr_r;
    logic [15:0] wb_da_r;
    logic [15:0] wb_db_r;
    logic rd_vld_r;
    logic [15:0] mem_rdata;

    // Bus decode
    wire acc = PSEL_I & PENABLE_I;
    wire sel_mem = PADDR_I >= MAS_OFF_MEM;
    wire wr_cmd = PWRITE_I & (PADDR_I == MAS_OFF_CMD);
    wire mapped = sel_mem | (PADDR_I <= MAS_OFF_ICLR && PADDR_I[1:0] == 2'b00);

    // Command fields
    wire [31:0] cmd = PWDATA_I;
    wire mas_op_t op = mas_op_t'(cmd[MAS_CMD_OP_LSB +: 2]);
    wire mas_mod_t md = mas_mod_t'(cmd[MAS_CMD_MOD_LSB +: 2]);
    wire opt_um = cmd[MAS_CMD_UM_BIT];
    wire opt_bz = cmd[MAS_CMD_BZ_BIT];
    wire opt_ae = cmd[MAS_CMD_AE_BIT];
    wire [7:0] idx = cmd[MAS_CMD_IDX_LSB +: 8];
    wire [7:0] usi = cmd[MAS_CMD_USI_LSB +: 8];

    // Store stall and access completion
    wire is_st = wr_cmd & (op == MAS_OP_STD);
    wire wb_busy = wb_r != MAS_WB_IDLE;
    wire st_stall = acc & is_st & wb_busy;
    wire rd_wait = sel_mem & ~PWRITE_I & ~rd_vld_r;
    assign PREADY_O = ~st_stall & ~rd_wait;
    wire done = acc & PREADY_O;
    assign PSLVERR_O = acc & ~mapped;
    wire wr_ok = done & PWRITE_I & mapped;
    wire do_cmd = wr_ok & (PADDR_I == MAS_OFF_CMD);
    wire do_alu = do_cmd & (op != MAS_OP_STD);
    wire do_st = do_cmd & (op == MAS_OP_STD);

    // ALU
    wire [15:0] opnd = (op == MAS_OP_ADD_IMMEDIATE) ? {8'h00, usi} : opb_r;
    wire is_sub = op == MAS_OP_SUB;
    wire [15:0] alu = is_sub ? opa_r - opnd : opa_r + opnd;
    wire ovf_add = (opa_r[15] == opnd[15]) & (alu[15] != opa_r[15]);
    wire ovf_sub = (opa_r[15] != opnd[15]) & (alu[15] != opa_r[15]);
    wire ovf = is_sub ? ovf_sub : ovf_add;
    wire is_mod = md != MAS_MOD_NONE;
    wire [15:0] modulo_32_select = {opa_r[15:5], alu[4:0]};
    wire [15:0] modulo_64_select = {opa_r[15:6], alu[5:0]};
    wire [15:0] final_res = (md == MAS_MOD_32) ? modulo_32_select :
        (md == MAS_MOD_64) ? modulo_64_select : alu;
    wire zero32 = alu[4:0] == 5'h00;
    wire zero64 = alu[5:0] == 6'h00;
    wire zero16 = alu == 16'h0000;
    wire is_zero = (md == MAS_MOD_32) ? zero32 :
        (md == MAS_MOD_64) ? zero64 : zero16;
    wire taken = opt_bz & is_zero;
    wire ovf_set = do_alu & ~is_mod & ovf;
    wire [4:0] seq_nxt = ~opt_bz ? MAS_SEQ_PLAIN :
        taken ? MAS_SEQ_TAKEN :
        opt_ae ? MAS_SEQ_ALL : MAS_SEQ_SQUASH;

    // Store addressing
    wire [15:0] st_byte = base_r + {8'h00, idx};
    wire [MEM_AW-1:0] st_hw = st_byte[MEM_AW:1];

    // Write buffer drain
    wire mem_free = ~MEM_BUSY_I;
    wire mem_we = mem_free & wb_busy;
    wire [MEM_AW-1:0] wb_pair =
        wb_addr_r ^ {{(MEM_AW-1){1'b0}}, 1'b1};
    wire [MEM_AW-1:0] mem_waddr = (wb_r == MAS_WB_SECOND) ? wb_pair
        : wb_addr_r;
    wire [15:0] mem_wdata = (wb_r == MAS_WB_SECOND) ? wb_db_r : wb_da_r;
    wire st_done = mem_we & (wb_r == MAS_WB_SECOND);
    mas_wb_t wb_nxt;

    always_comb begin
        case (wb_r)
            MAS_WB_IDLE: wb_nxt = do_st ? MAS_WB_FIRST : MAS_WB_IDLE;
            MAS_WB_FIRST: wb_nxt = mem_free ? MAS_WB_SECOND : MAS_WB_FIRST;
            MAS_WB_SECOND: wb_nxt = mem_free ? MAS_WB_IDLE : MAS_WB_SECOND;
            default: wb_nxt = MAS_WB_IDLE;
        endcase
    end

    mas_mem #(
        .AW(MEM_AW),
        .DW(16)
    ) u_mem (
        .clk_i(CLK_I),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(PADDR_I[MEM_AW+1:2]),
        .rdata_o(mem_rdata)
    );

    // Events and interrupt
    wire [MAS_EV_N-1:0] ev = {st_done, do_alu & taken, ovf_set};
    wire iclr = wr_ok & (PADDR_I == MAS_OFF_ICLR);
    wire [MAS_EV_N-1:0] clr = iclr ? PWDATA_I[MAS_EV_N-1:0] : '0;
    wire [MAS_EV_N-1:0] stat_nxt = ev | (stat_r & ~clr);
    assign IRQ_O = |(stat_r & ie_r);
    wire flag_clr = wr_ok & (PADDR_I == MAS_OFF_FLAG) & PWDATA_I[MAS_FLAG_OVF];
    wire ovf_nxt = ovf_set | (ovf_r & ~flag_clr);

    // Register writes
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            opa_r <= MAS_RST_HW;
            opb_r <= MAS_RST_HW;
            base_r <= MAS_RST_HW;
            fmlink_r <= MAS_RST_HW;
            ie_r <= '0;
        end else if (wr_ok) begin
            if (PADDR_I == MAS_OFF_OPA) opa_r <= PWDATA_I[15:0];
            if (PADDR_I == MAS_OFF_OPB) opb_r <= PWDATA_I[15:0];
            if (PADDR_I == MAS_OFF_BASE) base_r <= PWDATA_I[15:0];
            if (PADDR_I == MAS_OFF_FMLINK) fmlink_r <= PWDATA_I[15:0];
            if (PADDR_I == MAS_OFF_IE) ie_r <= PWDATA_I[MAS_EV_N-1:0];
        end
    end

    // ALU results
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            res_r <= MAS_RST_HW;
            brt_r <= 1'b0;
            seq_r <= MAS_RST_SEQ;
            fm_we_r <= 1'b0;
            fm_data_r <= MAS_RST_HW;
        end else begin
            fm_we_r <= do_alu & opt_um;
            if (do_alu) begin
                res_r <= final_res;
                brt_r <= taken;
                seq_r <= seq_nxt;
                fm_data_r <= final_res;
            end
        end
    end

    // Flags, status and write buffer
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ovf_r <= 1'b0;
            stat_r <= '0;
            wb_r <= MAS_WB_IDLE;
            wb_addr_r <= '0;
            wb_da_r <= MAS_RST_HW;
            wb_db_r <= MAS_RST_HW;
            rd_vld_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
            stat_r <= stat_nxt;
            wb_r <= wb_nxt;
            rd_vld_r <= acc & sel_mem & ~PWRITE_I & ~rd_vld_r;
            if (do_st) begin
                wb_addr_r <= st_hw;
                wb_da_r <= opa_r;
                wb_db_r <= opb_r;
            end
        end
    end

    assign FM_WE_O = fm_we_r;
    assign FM_ADDR_O = fmlink_r;
    assign FM_DATA_O = fm_data_r;

    // Read mux
    wire [31:0] flag_rd = {29'h0, wb_busy, brt_r, ovf_r};
    always_comb begin
        PRDATA_O = 32'h0000_0000;
        if (sel_mem) begin
            PRDATA_O = {16'h0000, mem_rdata};
        end else begin
            case (PADDR_I)
                MAS_OFF_OPA: PRDATA_O = {16'h0000, opa_r};
                MAS_OFF_OPB: PRDATA_O = {16'h0000, opb_r};
                MAS_OFF_RES: PRDATA_O = {16'h0000, res_r};
                MAS_OFF_FLAG: PRDATA_O = flag_rd;
                MAS_OFF_SEQ: PRDATA_O = {27'h0, seq_r};
                MAS_OFF_BASE: PRDATA_O = {16'h0000, base_r};
                MAS_OFF_FMLINK: PRDATA_O = {16'h0000, fmlink_r};
                MAS_OFF_STAT: PRDATA_O = {29'h0, stat_r};
                MAS_OFF_IE: PRDATA_O = {29'h0, ie_r};
                default: PRDATA_O = 32'h0000_0000;
            endcase
        end
    end

    // Checks
    a_pair_address: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        mem_we && wb_r == MAS_WB_FIRST |=> mem_waddr == ($past(mem_waddr)
        ^ 1) || wb_r == MAS_WB_FIRST)
        else $error("second halfword not at paired address");
    a_store_stall: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        acc && is_st && wb_busy |-> !PREADY_O)
        else $error("store accepted while buffer busy");
    a_no_stall: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        acc && !sel_mem && !wb_busy |-> PREADY_O)
        else $error("stall without busy buffer");
    a_add_immediate_zext: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && op == MAS_OP_ADD_IMMEDIATE && md == MAS_MOD_NONE |=>
        res_r == $past(opa_r) + {8'h00, $past(usi)})
        else $error("immediate add wrong");
    a_ovf_set: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && !is_mod && ovf |=> ovf_r && stat_r[MAS_EV_OVF])
        else $error("overflow not flagged");
    a_modulo_64_select_merge: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && md == MAS_MOD_64 |=> res_r[15:6] == $past(opa_r[15:6]))
        else $error("modulo 64 upper bits wrong");
    a_modulo_32_select_merge: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && md == MAS_MOD_32 |=> res_r[15:5] == $past(opa_r[15:5]))
        else $error("modulo 32 upper bits wrong");
    a_mod_keep_ovf: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && is_mod && !flag_clr |=> ovf_r == $past(ovf_r))
        else $error("modulo changed overflow");
    a_fm_update: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && opt_um |=> FM_WE_O && FM_DATA_O == res_r)
        else $error("fast memory not updated");
    a_zero_low32: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && opt_bz && md == MAS_MOD_32 |=> brt_r == (res_r[4:0] == 0))
        else $error("modulo 32 branch test wrong");
    a_taken_flow: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && taken |=> seq_r == MAS_SEQ_TAKEN)
        else $error("taken flow wrong");
    a_squash_flow: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && opt_bz && !taken |=> seq_r[1:0] == 2'b11 &&
        seq_r[4:3] == {2{$past(opt_ae)}})
        else $error("untaken flow wrong");
    a_store_capture: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_st |=> wb_da_r == $past(opa_r) && wb_db_r == $past(opb_r))
        else $error("store data not captured");
    a_wb_accept: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_st |=> wb_r == MAS_WB_FIRST)
        else $error("store not buffered");
    a_held_no_drain: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        MEM_BUSY_I |-> !mem_we)
        else $error("buffer drained while memory held");
    a_mod_keep_stat: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && is_mod && !stat_r[MAS_EV_OVF] |=> !stat_r[MAS_EV_OVF])
        else $error("modulo raised overflow event");
    a_fm_quiet: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && !opt_um |=> !FM_WE_O)
        else $error("fast memory written without update");
    a_zero_low64: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && opt_bz && md == MAS_MOD_64 |=>
        brt_r == (res_r[5:0] == 0))
        else $error("modulo 64 branch test wrong");
    a_plain_flow: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_alu && !opt_bz |=> seq_r == MAS_SEQ_PLAIN)
        else $error("plain flow wrong");
endmodule

//--- mas_pkg.sv
// Package: offsets, fields and encodings of the modulo ALU and store slice
package mas_pkg;
    // Register byte offsets
    localparam logic [11:0] MAS_OFF_OPA = 12'h000;
    localparam logic [11:0] MAS_OFF_OPB = 12'h004;
    localparam logic [11:0] MAS_OFF_CMD = 12'h008;
    localparam logic [11:0] MAS_OFF_RES = 12'h00c;
    localparam logic [11:0] MAS_OFF_FLAG = 12'h010;
    localparam logic [11:0] MAS_OFF_SEQ = 12'h014;
    localparam logic [11:0] MAS_OFF_BASE = 12'h018;
    localparam logic [11:0] MAS_OFF_FMLINK = 12'h01c;
    localparam logic [11:0] MAS_OFF_STAT = 12'h020;
    localparam logic [11:0] MAS_OFF_IE = 12'h024;
    localparam logic [11:0] MAS_OFF_ICLR = 12'h028;
    // Memory window: halfword n at byte MAS_OFF_MEM + 4*n
    localparam logic [11:0] MAS_OFF_MEM = 12'h400;
    // Command fields
    localparam int MAS_CMD_OP_LSB = 0;
    localparam int MAS_CMD_MOD_LSB = 2;
    localparam int MAS_CMD_UM_BIT = 4;
    localparam int MAS_CMD_BZ_BIT = 5;
    localparam int MAS_CMD_AE_BIT = 6;
    localparam int MAS_CMD_IDX_LSB = 8;
    localparam int MAS_CMD_USI_LSB = 16;
    // Flag bits
    localparam int MAS_FLAG_OVF = 0;
    localparam int MAS_FLAG_BRT = 1;
    localparam int MAS_FLAG_WBB = 2;
    // Status / interrupt bits
    localparam int MAS_EV_OVF = 0;
    localparam int MAS_EV_BRT = 1;
    localparam int MAS_EV_ST = 2;
    localparam int MAS_EV_N = 3;
    // Reset values
    localparam logic [15:0] MAS_RST_HW = 16'h0000;
    localparam logic [4:0] MAS_RST_SEQ = 5'h00;
    // Slot execute masks: next, seq+1, seq+2, target, target+1
    localparam logic [4:0] MAS_SEQ_PLAIN = 5'h07;
    localparam logic [4:0] MAS_SEQ_TAKEN = 5'h19;
    localparam logic [4:0] MAS_SEQ_SQUASH = 5'h07;
    localparam logic [4:0] MAS_SEQ_ALL = 5'h1f;
    // Operations
    typedef enum logic [1:0] {
        MAS_OP_ADD = 2'b00,
        MAS_OP_ADD_IMMEDIATE = 2'b01,
        MAS_OP_SUB = 2'b10,
        MAS_OP_STD = 2'b11
    } mas_op_t;
    // Modulo selection
    typedef enum logic [1:0] {
        MAS_MOD_NONE = 2'b00,
        MAS_MOD_32 = 2'b01,
        MAS_MOD_64 = 2'b10,
        MAS_MOD_RSV = 2'b11
    } mas_mod_t;
    // Write buffer states
    typedef enum logic [1:0] {
        MAS_WB_IDLE = 2'b00,
        MAS_WB_FIRST = 2'b01,
        MAS_WB_SECOND = 2'b10
    } mas_wb_t;
endpackage

//--- mas_mem.sv
// Halfword cell buffer memory with one write and one registered read port
module mas_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

//--- mas_far.sv
// Far side model: cell buffer contention and fast memory sink
module mas_far (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Contention request from the bench
    input wire logic hold_i,
    // Fast memory write port
    input wire logic fm_we_i,
    input wire logic [15:0] fm_addr_i,
    input wire logic [15:0] fm_data_i,
    // Model outputs
    output logic busy_o,
    output logic [15:0] last_addr_o,
    output logic [15:0] last_data_o,
    output int wr_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Other ports hold the cell buffer while asked to
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= hold_i;
        end
    end
    // Fast memory keeps the last write and a count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_addr_o <= 16'h0000;
            last_data_o <= 16'h0000;
            wr_count_o <= 0;
        end else if (fm_we_i) begin
            last_addr_o <= fm_addr_i;
            last_data_o <= fm_data_i;
            wr_count_o <= wr_count_o + 1;
        end
    end
endmodule

//--- testbench.sv
// Register level testbench of the modulo ALU and store slice
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mas_pkg::*;
    logic clk, rstn, psel, pen, pwr, pready, pslverr, busy, hold;
    logic fm_we, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] fm_addr, fm_data, la, ld;
    int fmc, waits, fail_count, total_checks;
    mas_top i_dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .MEM_BUSY_I(busy), .FM_WE_O(fm_we),
        .FM_ADDR_O(fm_addr), .FM_DATA_O(fm_data), .IRQ_O(irq));
    mas_far i_far (.clk_i(clk), .rstn_i(rstn), .hold_i(hold),
        .fm_we_i(fm_we), .fm_addr_i(fm_addr), .fm_data_i(fm_data),
        .busy_o(busy), .last_addr_o(la), .last_data_o(ld),
        .wr_count_o(fmc));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        waits = 0;
        do begin
            @(posedge clk);
            waits++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                      input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rdat & m, e);
    endtask
    function automatic logic [31:0] c(input mas_op_t op,
        input mas_mod_t md, input logic [2:0] o, input logic [7:0] ix,
        input logic [7:0] u);
        return (32'(op) << MAS_CMD_OP_LSB) | (32'(md) << MAS_CMD_MOD_LSB)
            | (32'(o) << MAS_CMD_UM_BIT) | (32'(ix) << MAS_CMD_IDX_LSB)
            | (32'(u) << MAS_CMD_USI_LSB);
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        fail_count++;
        finish_test();
    end
    initial begin
        {rstn, psel, pen, pwr, hold} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_count = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(MAS_OFF_RES, 32'hffff, 32'(MAS_RST_HW), "res reset");
        chk("no slverr", 32'(rerr), 0);
        rd(MAS_OFF_SEQ, 32'h1f, 32'(MAS_RST_SEQ), "seq reset");
        wr(MAS_OFF_FMLINK, 32'h0abc);
        // Signed overflow on add, then interrupt path
        wr(MAS_OFF_OPA, 32'h7fff);
        wr(MAS_OFF_OPB, 32'h0001);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD, MAS_MOD_NONE, 3'h0, 8'h00, 8'h00));
        rd(MAS_OFF_RES, 32'hffff, 32'h8000, "add res");
        rd(MAS_OFF_FLAG, 32'h1, 32'h1, "add ovf");
        rd(MAS_OFF_SEQ, 32'h1f, 32'(MAS_SEQ_PLAIN), "plain seq");
        #1 chk("irq masked", irq, 0);
        wr(MAS_OFF_IE, 32'h1);
        #1 chk("irq on", irq, 1);
        wr(MAS_OFF_ICLR, 32'h1);
        #1 chk("irq clr", irq, 0);
        wr(MAS_OFF_FLAG, 32'h1);
        // Immediate with top bit set stays unsigned
        wr(MAS_OFF_OPA, 32'h1234);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD_IMMEDIATE, MAS_MOD_NONE, 3'h0, 8'h00, 8'hf0));
        rd(MAS_OFF_RES, 32'hffff, 32'h1324, "add_immediate res");
        // Subtract overflow
        wr(MAS_OFF_OPA, 32'h8000);
        wr(MAS_OFF_CMD, c(MAS_OP_SUB, MAS_MOD_NONE, 3'h0, 8'h00, 8'h00));
        rd(MAS_OFF_RES, 32'hffff, 32'h7fff, "sub res");
        rd(MAS_OFF_FLAG, 32'h1, 32'h1, "sub ovf");
        wr(MAS_OFF_FLAG, 32'h1);
        // Modulo 32, zero low bits, update option
        wr(MAS_OFF_OPA, 32'h7fff);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD, MAS_MOD_32, 3'h3, 8'h00, 8'h00));
        rd(MAS_OFF_RES, 32'hffff, 32'h7fe0, "modulo_32_select res");
        rd(MAS_OFF_FLAG, 32'h1, 32'h0, "modulo_32_select ovf");
        rd(MAS_OFF_SEQ, 32'h1f, 32'(MAS_SEQ_TAKEN), "taken");
        rd(MAS_OFF_FLAG, 32'h2, 32'h2, "brt set");
        chk("fm data", 32'(ld), 32'h7fe0);
        chk("fm addr", 32'(la), 32'h0abc);
        // Modulo 64 overflowing immediate, untaken, always execute
        wr(MAS_OFF_OPA, 32'h7ffe);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD_IMMEDIATE, MAS_MOD_64, 3'h7, 8'h00, 8'h45));
        rd(MAS_OFF_RES, 32'hffff, 32'h7fc3, "modulo_64_select res");
        rd(MAS_OFF_FLAG, 32'h1, 32'h0, "modulo_64_select ovf");
        rd(MAS_OFF_SEQ, 32'h1f, 32'(MAS_SEQ_ALL), "always");
        rd(MAS_OFF_FLAG, 32'h2, 32'h0, "brt clr");
        chk("fm data2", 32'(ld), 32'h7fc3);
        // Modulo 32 untaken squashes target slots
        wr(MAS_OFF_OPA, 32'h0001);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD_IMMEDIATE, MAS_MOD_32, 3'h2, 8'h00, 8'h1a));
        rd(MAS_OFF_RES, 32'hffff, 32'h001b, "modulo_32_select nz");
        rd(MAS_OFF_SEQ, 32'h1f, 32'(MAS_SEQ_SQUASH), "squash");
        // Stores against a held cell buffer
        wr(MAS_OFF_BASE, 32'h0010);
        wr(MAS_OFF_OPA, 32'haaaa);
        wr(MAS_OFF_OPB, 32'h5555);
        hold <= 1'b1;
        wr(MAS_OFF_CMD, c(MAS_OP_STD, MAS_MOD_NONE, 3'h0, 8'h04, 8'h00));
        chk("st1 wait", waits, 1);
        rd(MAS_OFF_FLAG, 32'h4, 32'h4, "wb busy");
        wr(MAS_OFF_OPA, 32'h1111);
        wr(MAS_OFF_OPB, 32'h2222);
        wr(MAS_OFF_CMD, c(MAS_OP_ADD, MAS_MOD_NONE, 3'h0, 8'h00, 8'h00));
        chk("alu wait", waits, 1);
        fork
            begin
                repeat (20) @(posedge clk);
                hold <= 1'b0;
            end
        join_none
        wr(MAS_OFF_CMD, c(MAS_OP_STD, MAS_MOD_NONE, 3'h0, 8'h27, 8'h00));
        chk("st2 stall", 32'(waits > 18), 1);
        repeat (6) @(posedge clk);
        rd(MAS_OFF_MEM + 12'h028, 32'hffff, 32'haaaa, "m0a");
        chk("mem wait", waits, 2);
        rd(MAS_OFF_MEM + 12'h02c, 32'hffff, 32'h5555, "m0b");
        rd(MAS_OFF_MEM + 12'h06c, 32'hffff, 32'h1111, "m1b");
        rd(MAS_OFF_MEM + 12'h068, 32'hffff, 32'h2222, "m1a");
        rd(MAS_OFF_STAT, 32'h4, 32'h4, "st done");
        // Unmapped address
        apb(1'b0, 12'h02c, 32'h0);
        chk("slverr", 32'(rerr), 1);
        chk("unmap rd", rdat, 0);
        chk("fm count", fmc, 2);
        finish_test();
    end
endmodule
